// [core/dma_defs.vh]
// constants for the dma transfer-cycle engine
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH
// data path width codes (per channel, target and requester)
`define WIDTH_8 2'b00
`define WIDTH_16 2'b01
`define WIDTH_32 2'b10
`define WIDTH_RST 2'b00
// transfer types
`define TYPE_VERIFY 2'b00
`define TYPE_READ 2'b01
`define TYPE_WRITE 2'b10
`define TYPE_RST 2'b01
// buffer transfer modes
`define MODE_SINGLE 2'b00
`define MODE_DEMAND 2'b01
`define MODE_BLOCK 2'b10
`define MODE_RST 2'b00
// sequencer states
`define ST_IDLE 3'h0
`define ST_WAIT_ACK 3'h1
`define ST_ARB 3'h2
`define ST_SETUP 3'h3
`define ST_BUSY 3'h4
`define ST_TERM 3'h5
`define ST_RELEASE 3'h6
// priority ring: upper ring position 4 is the whole lower group
`define UPPER_RING 5
`define LOWER_ENTRY 3'h4
`define UPPER_LOWEST_RST 2'h3
`define LOWER_LOWEST_RST 2'h3
`endif

// [core/dma_transfer_cycle_engine.v]
// eight-channel dma transfer-cycle, arbitration and bus takeover engine
`timescale 1ns/100ps
`include "dma_defs.vh"
module dma_transfer_cycle_engine (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // requests and host handshake
    input wire [7:0] channel_service_request,
    input wire [7:0] sw_request,
    input wire hold_acknowledge,
    input wire end_of_process_n,
    output reg hold_request,
    output reg [7:0] channel_acknowledge,
    // bus cycle
    output reg [31:2] bus_address,
    output reg [3:0] byte_lane_enables_n,
    output reg mem_io,
    output reg write_read,
    output reg cycle_start,
    output reg [31:0] data_out,
    output reg data_oe_n,
    input wire bus_ready,
    input wire [31:0] data_in,
    // channel programming
    input wire cfg_write,
    input wire [2:0] cfg_chan,
    input wire cfg_fly,
    input wire [1:0] cfg_type,
    input wire [1:0] cfg_mode,
    input wire [1:0] cfg_target_width,
    input wire [1:0] cfg_req_width,
    input wire cfg_target_mem,
    input wire cfg_req_mem,
    input wire [31:0] cfg_target_addr,
    input wire [31:0] cfg_req_addr,
    input wire [23:0] cfg_count,
    // priority control
    input wire upper_rotate,
    input wire lower_rotate,
    input wire prio_write,
    input wire prio_upper,
    input wire [1:0] prio_lowest,
    // status
    output reg [7:0] count_expired,
    output reg [7:0] channel_masked
);

// per-channel state
reg [31:0] taddr [0:7];
reg [31:0] raddr [0:7];
reg [23:0] count [0:7];
reg [31:0] temp [0:7];
reg [2:0] fill [0:7];
reg cfly [0:7];
reg [1:0] ctype [0:7];
reg [1:0] cmode [0:7];
reg [1:0] ctw [0:7];
reg [1:0] crw [0:7];
reg ctm [0:7];
reg crm [0:7];
// sequencer
reg [2:0] state;
reg [2:0] cur;
reg wr;
reg term_flag;
reg stop_flag;
reg [7:0] swreq;
// priority pointers: position of the lowest-priority entry
reg [2:0] uptr_r;
reg [1:0] lptr_r;
reg [1:0] uprog;
reg [1:0] lprog;
// pin synchronisers
reg [7:0] req_m;
reg [7:0] req_s;
reg hold_acknowledge_m;
reg hold_acknowledge_s;
reg eop_m;
reg eop_s;

// two flops on the request, hold acknowledge and end-of-process pins before anything looks at them
always @(posedge mclk) begin
    if (!rstn) begin
        req_m <= 8'h00;
        req_s <= 8'h00;
        hold_acknowledge_m <= 1'b0;
        hold_acknowledge_s <= 1'b0;
        eop_m <= 1'b1;
        eop_s <= 1'b1;
    end else begin
        req_m <= channel_service_request;
        req_s <= req_m;
        hold_acknowledge_m <= hold_acknowledge;
        hold_acknowledge_s <= hold_acknowledge_m;
        eop_m <= end_of_process_n;
        eop_s <= eop_m;
    end
end

// hardware and software requests are merged before arbitration
wire [7:0] pend = (req_s | swreq) & ~channel_masked;
wire [2:0] uptr = upper_rotate ? uptr_r : {1'b0, uprog};
wire [1:0] lptr = lower_rotate ? lptr_r : lprog;

// cascade arbiter: scan from lowest back to highest, last hit wins
reg [4:0] ucand;
reg [1:0] lower_win;
reg [1:0] lidx;
reg [2:0] uw;
reg upper_hit;
reg [2:0] win_ch;
integer ai;
integer at;
always @* begin
    ucand = {|pend[3:0], pend[7:4]};
    lower_win = 2'h0;
    lidx = 2'h0;
    uw = 3'h0;
    upper_hit = 1'b0;
    at = 0;
    for (ai = 4; ai >= 1; ai = ai - 1) begin
        lidx = lptr + ai[1:0];
        if (pend[lidx])
            lower_win = lidx;
    end
    for (ai = `UPPER_RING; ai >= 1; ai = ai - 1) begin
        at = uptr + ai;
        if (at >= `UPPER_RING)
            at = at - `UPPER_RING;
        if (ucand[at]) begin
            upper_hit = 1'b1;
            uw = at[2:0];
        end
    end
    // ring order 4,5,6,7,lower: lower sits between 7 and 4
    if (uw == `LOWER_ENTRY)
        win_ch = {1'b0, lower_win};
    else
        win_ch = {1'b1, uw[1:0]};
end

// access shaping for the selected channel
wire launch = (state == `ST_ARB && upper_hit) || state == `ST_SETUP;
wire [2:0] sel = (state == `ST_ARB) ? win_ch : cur;
wire [1:0] typ = ctype[sel];
wire fly = cfly[sel];
wire verify = (typ == `TYPE_VERIFY);
wire src_t = (typ != `TYPE_WRITE);
wire [2:0] tb = 3'd1 << ctw[sel];
wire [2:0] rb = 3'd1 << crw[sel];
wire [2:0] sb = src_t ? tb : rb;
wire [2:0] db = src_t ? rb : tb;
wire [31:0] sa = src_t ? taddr[sel] : raddr[sel];
wire [31:0] da = src_t ? raddr[sel] : taddr[sel];
wire [2:0] f = fill[sel];
wire [2:0] goal = verify ? sb : db;
wire [23:0] cnt = count[sel];
wire [31:0] tmp = temp[sel];
// a fresh service resumes with whatever the temp register still holds
wire wr_eff = (state == `ST_ARB) ? (!verify && f >= goal) : wr;
wire stopcond = (cmode[sel] == `MODE_SINGLE) ||
                (cmode[sel] == `MODE_DEMAND && !req_s[sel]);

reg [2:0] n;
reg [2:0] m;
reg [2:0] acc_n;
reg [31:0] acc_a;
reg [3:0] lanes;
reg to_target;
reg [31:0] rd_tmp;
reg [31:0] wdata;
reg [31:0] sh_tmp;
integer bk;
integer bj;
integer bs;
always @*begin
    bj = 0;
    bs = 0;
    // reads fill the temp register; unaligned or short ones go bytewise
    if (sb <= 3'd4 - f && ({1'b0, sa[1:0]} & (sb - 3'd1)) == 3'd0 &&
        cnt >= {21'h0, sb})
        n = sb;
    else
        n = 3'd1;
    if (f >= db && ({1'b0, da[1:0]} & (db - 3'd1)) == 3'd0)
        m = db;
    else
        m = 3'd1;
    acc_n = fly ? tb : (wr_eff ? m : n);
    acc_a = fly ? taddr[sel] : (wr_eff ? da : sa);
    if (acc_n == 3'd4)
        lanes = 4'hf;
    else if (acc_n == 3'd2)
        lanes = 4'h3;
    else
        lanes = 4'h1;
    lanes = lanes << acc_a[1:0];
    to_target = fly || (wr_eff ? !src_t : src_t);
    // byte assembly into the temp register
    rd_tmp = tmp;
    for (bk = 0; bk < 4; bk = bk + 1) begin
        bj = f + bk;
        bs = sa[1:0] + bk;
        if (bk < n && bj < 4 && bs < 4)
            rd_tmp[8*bj +: 8] = data_in[8*bs +: 8];
    end
    // byte disassembly onto destination lanes
    wdata = 32'h0;
    for (bk = 0; bk < 4; bk = bk + 1) begin
        bs = da[1:0] + bk;
        if (bk < m && bs < 4)
            wdata[8*bs +: 8] = tmp[8*bk +: 8];
    end
    sh_tmp = tmp >> (8 * m);
end

// main sequencer
integer ri;
always @(posedge mclk) begin
    if (!rstn) begin
        state <= `ST_IDLE;
        cur <= 3'h0;
        wr <= 1'b0;
        term_flag <= 1'b0;
        stop_flag <= 1'b0;
        swreq <= 8'h00;
        uptr_r <= {1'b0, `UPPER_LOWEST_RST};
        lptr_r <= `LOWER_LOWEST_RST;
        uprog <= `UPPER_LOWEST_RST;
        lprog <= `LOWER_LOWEST_RST;
        hold_request <= 1'b0;
        channel_acknowledge <= 8'h00;
        bus_address <= 30'h0;
        byte_lane_enables_n <= 4'hf;
        mem_io <= 1'b0;
        write_read <= 1'b0;
        cycle_start <= 1'b0;
        data_out <= 32'h0;
        data_oe_n <= 1'b1;
        count_expired <= 8'h00;
        channel_masked <= 8'h00;
        for (ri = 0; ri < 8; ri = ri + 1) begin
            taddr[ri] <= 32'h0;
            raddr[ri] <= 32'h0;
            count[ri] <= 24'h0;
            temp[ri] <= 32'h0;
            fill[ri] <= 3'h0;
            cfly[ri] <= 1'b0;
            ctype[ri] <= `TYPE_RST;
            cmode[ri] <= `MODE_RST;
            ctw[ri] <= `WIDTH_RST;
            crw[ri] <= `WIDTH_RST;
            ctm[ri] <= 1'b1;
            crm[ri] <= 1'b0;
        end
    end else begin
        cycle_start <= 1'b0;
        // a software request arriving with its clear is kept
        swreq <= (swreq & ~((state == `ST_TERM) ? (8'h01 << cur) : 8'h00))
                 | sw_request;
        // programmed lowest only accepted while that group is fixed
        if (prio_write && prio_upper && !upper_rotate)
            uprog <= prio_lowest;
        if (prio_write && !prio_upper && !lower_rotate)
            lprog <= prio_lowest;
        // fixed groups keep the rotating copy in step, so switching over
        // to rotating starts from the levels now in force
        if (!upper_rotate)
            uptr_r <= {1'b0, uprog};
        if (!lower_rotate)
            lptr_r <= lprog;
        case (state)
        `ST_IDLE: begin
            // re-request only after the previous handshake has closed
            if (pend != 8'h00 && !hold_acknowledge_s) begin
                hold_request <= 1'b1;
                state <= `ST_WAIT_ACK;
            end
        end
        `ST_WAIT_ACK: begin
            if (hold_acknowledge_s)
                state <= `ST_ARB;
        end
        `ST_ARB: begin
            stop_flag <= 1'b0;
            term_flag <= 1'b0;
            if (!upper_hit) begin
                state <= `ST_RELEASE;
            end else begin
                cur <= win_ch;
                wr <= wr_eff;
                if (upper_rotate) begin
                    if (win_ch[2])
                        uptr_r <= {1'b0, win_ch[1:0]};
                    else
                        uptr_r <= `LOWER_ENTRY;
                end
                if (lower_rotate && !win_ch[2])
                    lptr_r <= win_ch[1:0];
            end
        end
        `ST_SETUP: begin
        end
        `ST_BUSY: begin
            if (bus_ready) begin
                channel_acknowledge <= 8'h00;
                byte_lane_enables_n <= 4'hf;
                data_oe_n <= 1'b1;
                state <= `ST_SETUP;
                if (fly) begin
                    // count steps by target size only
                    count[cur] <= (cnt > {21'h0, tb}) ?
                                  cnt - {21'h0, tb} : 24'h0;
                    taddr[cur] <= taddr[cur] + {29'h0, tb};
                    if (cnt <= {21'h0, tb} || !eop_s)
                        state <= `ST_TERM;
                    else if (stopcond)
                        state <= `ST_RELEASE;
                end else if (!wr) begin
                    count[cur] <= cnt - {21'h0, n};
                    if (src_t)
                        taddr[cur] <= taddr[cur] + {29'h0, n};
                    else
                        raddr[cur] <= raddr[cur] + {29'h0, n};
                    if (!verify) begin
                        temp[cur] <= rd_tmp;
                        fill[cur] <= f + n;
                    end
                    term_flag <= cnt == {21'h0, n} || !eop_s;
                    stop_flag <= !src_t && stopcond;
                    // write only once full, or early when the process ends
                    if (!verify && (f + n >= goal ||
                        ((cnt == {21'h0, n} || !eop_s) && f + n != 3'd0)))
                        wr <= 1'b1;
                    else if (cnt == {21'h0, n} || !eop_s)
                        state <= `ST_TERM;
                    else if (!src_t && stopcond)
                        state <= `ST_RELEASE;
                end else begin
                    if (src_t)
                        raddr[cur] <= raddr[cur] + {29'h0, m};
                    else
                        taddr[cur] <= taddr[cur] + {29'h0, m};
                    temp[cur] <= sh_tmp;
                    fill[cur] <= f - m;
                    if (term_flag) begin
                        if (f == m)
                            state <= `ST_TERM;
                    end else if (stop_flag || (src_t && stopcond)) begin
                        state <= `ST_RELEASE;
                    end else if (f - m == 3'd0 || f - m < db) begin
                        wr <= 1'b0;
                    end
                end
            end
        end
        `ST_TERM: begin
            channel_masked[cur] <= 1'b1;
            count_expired[cur] <= 1'b1;
            fill[cur] <= 3'h0;
            state <= `ST_RELEASE;
        end
        `ST_RELEASE: begin
            hold_request <= 1'b0;
            if (!hold_acknowledge_s && !hold_request)
                state <= `ST_IDLE;
        end
        default: state <= `ST_IDLE;
        endcase
        // drive a new access; outputs stand until the ready
        if (launch) begin
            state <= `ST_BUSY;
            cycle_start <= 1'b1;
            bus_address <= acc_a[31:2];
            byte_lane_enables_n <= ~lanes;
            mem_io <= to_target ? ctm[sel] : crm[sel];
            // fly-by shows the target side; requester does the opposite
            write_read <= fly ? (typ == `TYPE_WRITE) : wr_eff;
            channel_acknowledge <= ((fly && !verify) || !to_target) ?
                                   (8'h01 << sel) : 8'h00;
            // fly-by never drives data, the temp register stays put
            data_out <= wdata;
            data_oe_n <= fly || !wr_eff;
        end
        // programming a channel reloads it and lifts its mask
        if (cfg_write) begin
            cfly[cfg_chan] <= cfg_fly;
            ctype[cfg_chan] <= cfg_type;
            cmode[cfg_chan] <= cfg_mode;
            ctw[cfg_chan] <= cfg_target_width;
            crw[cfg_chan] <= cfg_req_width;
            ctm[cfg_chan] <= cfg_target_mem;
            crm[cfg_chan] <= cfg_req_mem;
            taddr[cfg_chan] <= cfg_target_addr;
            raddr[cfg_chan] <= cfg_req_addr;
            count[cfg_chan] <= cfg_count;
            fill[cfg_chan] <= 3'h0;
            // a termination landing in the same cycle still stands
            channel_masked[cfg_chan] <= (state == `ST_TERM && cur == cfg_chan);
            count_expired[cfg_chan] <= (state == `ST_TERM && cur == cfg_chan);
        end
    end
end

endmodule

// [sim/dma_engine_checker_assertions.sv]
// port-level checks for the dma transfer-cycle engine
`timescale 1ns/100ps
module dma_engine_checker (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // handshake
    input wire hold_acknowledge,
    input wire hold_request,
    input wire [7:0] channel_acknowledge,
    // bus cycle
    input wire [31:2] bus_address,
    input wire [3:0] byte_lane_enables_n,
    input wire mem_io,
    input wire write_read,
    input wire cycle_start,
    input wire data_oe_n,
    input wire bus_ready,
    // status
    input wire [7:0] count_expired,
    input wire [7:0] channel_masked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // an access is open while any lane is enabled
    wire busy = byte_lane_enables_n != 4'hf;

    a_ack_one_hot: assert property (channel_acknowledge != 8'h00 |->
        $onehot(channel_acknowledge) && hold_request)
        else $error("acknowledge not one-hot under hold");
    a_start_pulse: assert property (cycle_start |=> !cycle_start)
        else $error("start pulse longer than one cycle");
    a_access_holds: assert property (busy && !bus_ready |=>
        $stable(bus_address) && $stable(byte_lane_enables_n) &&
        $stable(write_read) && $stable(mem_io))
        else $error("access changed before ready");
    a_access_ends: assert property (busy && bus_ready |=> !busy &&
        channel_acknowledge == 8'h00 && data_oe_n)
        else $error("access not closed after ready");
    a_grant_first: assert property (hold_request && $rose(hold_acknowledge)
        |-> ##[2:4] cycle_start)
        else $error("first access late after grant");
    a_no_rerequest: assert property (hold_acknowledge && !hold_request
        |=> !hold_request)
        else $error("hold re-requested before grant dropped");
    a_idle_quiet: assert property (!hold_request |-> !busy &&
        channel_acknowledge == 8'h00 && data_oe_n)
        else $error("bus driven without hold");
    a_drive_write: assert property (!data_oe_n |-> write_read && busy)
        else $error("data driven outside a write");
    a_status_pair: assert property ($changed(count_expired) |->
        count_expired == channel_masked)
        else $error("expired and masked differ");

    cover property (!data_oe_n && bus_ready);
    cover property ($rose(hold_request));
    cover property (busy && !bus_ready ##1 bus_ready);
endmodule

bind dma_transfer_cycle_engine dma_engine_checker dma_engine_checker_i (
    .mclk(mclk), .rstn(rstn), .hold_acknowledge(hold_acknowledge),
    .hold_request(hold_request), .channel_acknowledge(channel_acknowledge),
    .bus_address(bus_address), .byte_lane_enables_n(byte_lane_enables_n),
    .mem_io(mem_io), .write_read(write_read), .cycle_start(cycle_start),
    .data_oe_n(data_oe_n), .bus_ready(bus_ready),
    .count_expired(count_expired), .channel_masked(channel_masked));

// [sim/host_bus_model.sv]
// host processor and bus slave stand-in facing the dma engine
`timescale 1ns/100ps
module host_bus_model (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // engine side
    input wire hold_request,
    input wire cycle_start,
    input wire write_read,
    input wire [31:2] bus_address,
    input wire [3:0] byte_lane_enables_n,
    input wire slow,
    // answers
    output reg hold_acknowledge,
    output reg bus_ready,
    output wire [31:0] data_in
);
    reg [1:0] grant_dly;
    reg [2:0] wait_cnt;
    reg busy;
    reg [31:0] last;
    wire [5:0] w = bus_address[7:2];
    wire reading = byte_lane_enables_n != 4'hf && !write_read;
    // each lane returns its byte address during a read; outside reads the whole bus toggles, never holds
    assign data_in = reading ? {w, 2'd3, w, 2'd2, w, 2'd1, w, 2'd0} : ~last;
    // grant and release follow hold after three cycles; slow adds waits
    always @(posedge mclk) begin
        if (!rstn) begin
            grant_dly <= 2'b00;
            hold_acknowledge <= 1'b0;
            bus_ready <= 1'b0;
            busy <= 1'b0;
            wait_cnt <= 3'd0;
            last <= 32'h00000000;
        end else begin
            grant_dly <= {grant_dly[0], hold_request};
            hold_acknowledge <= grant_dly[1];
            last <= data_in;
            bus_ready <= 1'b0;
            if (cycle_start) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 3'd4 : 3'd0;
            end else if (busy) begin
                if (wait_cnt == 3'd0) begin
                    bus_ready <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt - 3'd1;
                end
            end
        end
    end
endmodule

// [sim/dma_transfer_cycle_engine_tb.sv]
// self-checking bench for the dma transfer-cycle engine
`timescale 1ns/100ps
`include "dma_defs.vh"
module dma_transfer_cycle_engine_tb;
    typedef struct {
        logic [2:0] ch;
        logic fly;
        logic [1:0] typ, mode, tw, rw;
        logic [23:0] cnt;
        logic [31:0] nr, nw, mask, wd;
    } row_t;
    reg mclk = 1'b0;
    reg rstn = 1'b0;
    reg slow = 1'b0;
    reg eop_n = 1'b1;
    reg [7:0] req = 8'h00;
    reg [7:0] sw = 8'h00;
    reg cfg_write = 1'b0;
    reg [2:0] cfg_chan = 3'h0;
    reg cfg_fly = 1'b0;
    reg [1:0] cfg_type = 2'h0, cfg_mode = 2'h0, cfg_tw = 2'h0, cfg_rw = 2'h0;
    reg [23:0] cfg_count = 24'h000000;
    reg upper_rotate = 1'b0, lower_rotate = 1'b0;
    reg prio_write = 1'b0, prio_upper = 1'b0;
    reg [1:0] prio_lowest = 2'h0;
    wire hold_request, hold_acknowledge, mem_io, write_read, cycle_start;
    wire data_oe_n, bus_ready;
    wire [7:0] channel_acknowledge, count_expired, channel_masked;
    wire [31:2] bus_address;
    wire [3:0] byte_lane_enables_n;
    wire [31:0] data_out, data_in;
    int errors = 0, compares = 0, nr, nw, n;
    logic [31:0] wdata, got, ad;
    logic [3:0] sp, ln;
    logic [7:0] log[$];
    // widths match on fly-by rows; the last row stops on a partial fill
    row_t rows[6] = '{
        '{0, 0, `TYPE_WRITE, `MODE_SINGLE, `WIDTH_32, `WIDTH_8, 4, 4, 1,
          32'hffffffff, 32'h23222120},
        '{1, 1, `TYPE_READ, `MODE_BLOCK, `WIDTH_32, `WIDTH_32, 8, 2, 0, 0, 0},
        '{2, 1, `TYPE_WRITE, `MODE_DEMAND, `WIDTH_16, `WIDTH_16, 4, 0, 2, 0, 0},
        '{5, 0, `TYPE_VERIFY, `MODE_BLOCK, `WIDTH_8, `WIDTH_8, 3, 3, 0, 0, 0},
        '{7, 0, `TYPE_READ, `MODE_BLOCK, `WIDTH_32, `WIDTH_8, 4, 1, 4,
          32'hff000000, 32'h43000000},
        '{3, 0, `TYPE_WRITE, `MODE_BLOCK, `WIDTH_32, `WIDTH_8, 3, 3, 3,
          32'h00ffffff, 32'h00220000}};

    always #4 mclk = ~mclk;

    dma_transfer_cycle_engine dma_transfer_cycle_engine_i (
        .mclk(mclk), .rstn(rstn), .channel_service_request(req),
        .sw_request(sw), .hold_acknowledge(hold_acknowledge),
        .end_of_process_n(eop_n), .hold_request(hold_request),
        .channel_acknowledge(channel_acknowledge), .bus_address(bus_address),
        .byte_lane_enables_n(byte_lane_enables_n), .mem_io(mem_io),
        .write_read(write_read), .cycle_start(cycle_start),
        .data_out(data_out), .data_oe_n(data_oe_n), .bus_ready(bus_ready),
        .data_in(data_in), .cfg_write(cfg_write), .cfg_chan(cfg_chan),
        .cfg_fly(cfg_fly), .cfg_type(cfg_type), .cfg_mode(cfg_mode),
        .cfg_target_width(cfg_tw), .cfg_req_width(cfg_rw),
        .cfg_target_mem(1'b1), .cfg_req_mem(1'b0),
        .cfg_target_addr(32'h00000040), .cfg_req_addr(32'h00000020),
        .cfg_count(cfg_count), .upper_rotate(upper_rotate),
        .lower_rotate(lower_rotate), .prio_write(prio_write),
        .prio_upper(prio_upper), .prio_lowest(prio_lowest),
        .count_expired(count_expired), .channel_masked(channel_masked));

    host_bus_model host_bus_model_i (
        .mclk(mclk), .rstn(rstn), .hold_request(hold_request),
        .cycle_start(cycle_start), .write_read(write_read),
        .bus_address(bus_address), .byte_lane_enables_n(byte_lane_enables_n),
        .slow(slow), .hold_acknowledge(hold_acknowledge),
        .bus_ready(bus_ready), .data_in(data_in));

    // tally completed accesses and the order of acknowledged requesters
    always @(posedge mclk) begin
        if (byte_lane_enables_n !== 4'hf && bus_ready === 1'b1) begin
            sp = {sp[1:0], mem_io, write_read};
            ad = {bus_address, 2'b00};
            ln = byte_lane_enables_n;
            if (write_read === 1'b1) begin
                nw = nw + 1;
                wdata = data_out;
            end else begin
                nr = nr + 1;
            end
        end
        if (cycle_start === 1'b1 && channel_acknowledge !== 8'h00)
            log.push_back(channel_acknowledge);
    end

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic row_t mk(input logic [2:0] ch, input logic [1:0] md,
                                input logic [23:0] cnt);
        mk = '{ch, 1, `TYPE_READ, md, `WIDTH_8, `WIDTH_8, cnt, 0, 0, 0, 0};
    endfunction

    task automatic setup_chan(input row_t r);
        cfg_chan = r.ch;
        cfg_fly = r.fly;
        cfg_type = r.typ;
        cfg_mode = r.mode;
        cfg_tw = r.tw;
        cfg_rw = r.rw;
        cfg_count = r.cnt;
        cfg_write = 1'b1;
        tick;
        cfg_write = 1'b0;
        tick;
    endtask

    // bounded wait for termination, then for the bus to be handed back
    task automatic wait_done(input logic [7:0] m);
        n = 0;
        while ((count_expired & m) !== m && n < 3000) begin
            tick;
            n++;
        end
        req = 8'h00;
        while ((hold_request | hold_acknowledge) !== 1'b0 && n < 3000) begin
            tick;
            n++;
        end
        if (n >= 3000) begin
            errors++;
            results;
        end else begin
            repeat (4) tick;
        end
    endtask

    // raise requests by pin or by software pulse, compare service order
    task automatic serve(input logic [7:0] m, input bit hw,
                         input logic [31:0] exp);
        log.delete();
        if (hw) begin
            req = m;
        end else begin
            sw = m;
            tick;
            sw = 8'h00;
        end
        wait_done(m);
        got = 0;
        foreach (log[k]) got = {got[23:0], log[k]};
        check(got, exp);
    endtask

    initial begin
        repeat (8) tick;
        check({hold_request, channel_acknowledge, byte_lane_enables_n,
               data_oe_n, count_expired}, {1'b0, 8'h00, 4'hf, 1'b1, 8'h00});
        rstn = 1'b1;
        tick;
        foreach (rows[i]) begin
            slow = i[0];
            setup_chan(rows[i]);
            nr = 0;
            nw = 0;
            wdata = 0;
            req[rows[i].ch] = 1'b1;
            wait_done(8'h01 << rows[i].ch);
            check(nr, rows[i].nr);
            check(nw, rows[i].nw);
            check(wdata & rows[i].mask, rows[i].wd);
            check(channel_masked[rows[i].ch], 1'b1);
        end
        // end of process on the first byte: that byte alone is flushed
        eop_n = 1'b0;
        setup_chan(rows[5]);
        nr = 0;
        nw = 0;
        req[3] = 1'b1;
        wait_done(8'h08);
        eop_n = 1'b1;
        check(nr, 1);
        check(nw, 1);
        check(wdata, 32'h00000020);
        check(ln, 4'he);
        check(sp, 4'h3);
        // hold request three edges after the pin, two for synchronising
        setup_chan(mk(4, `MODE_BLOCK, 1));
        req = 8'h10;
        n = 0;
        while (hold_request !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        check(n, 3);
        wait_done(8'h10);
        check(ad, 32'h00000040);
        check(sp[1:0], 2'b10);
        setup_chan(mk(0, `MODE_SINGLE, 2));
        setup_chan(mk(1, `MODE_SINGLE, 2));
        serve(8'h03, 1, 32'h01010202);
        lower_rotate = 1'b1;
        setup_chan(mk(0, `MODE_SINGLE, 2));
        setup_chan(mk(1, `MODE_SINGLE, 2));
        serve(8'h03, 1, 32'h01020102);
        // channel 5 lowest in the upper ring: 6, 7, lower group, 4, 5
        lower_rotate = 1'b0;
        prio_upper = 1'b1;
        prio_lowest = 2'h1;
        prio_write = 1'b1;
        tick;
        prio_write = 1'b0;
        setup_chan(mk(0, `MODE_BLOCK, 1));
        setup_chan(mk(4, `MODE_BLOCK, 1));
        setup_chan(mk(6, `MODE_BLOCK, 1));
        serve(8'h51, 1, 32'h00400110);
        setup_chan(mk(6, `MODE_BLOCK, 1));
        serve(8'h40, 0, 32'h00000040);
        results;
    end

    // a hang is cut off well past the expected run length
    initial begin
        #400000;
        errors++;
        results;
    end
endmodule
